//--- design/vdpc_params.svh
/*
  Constants of the video digitizer pin control block: addresses, counts,
  reset values. Assumes a 50 MHz core clock.
*/
`ifndef VDPC_PARAMS_SVH
`define VDPC_PARAMS_SVH

`define VDPC_CLK_PERIOD_NS 20
`define VDPC_RST_MIN_NS 1000
`define VDPC_RST_MIN_CYC \
  ((`VDPC_RST_MIN_NS + `VDPC_CLK_PERIOD_NS - 1) / `VDPC_CLK_PERIOD_NS)
`define VDPC_ADDR_LOW 7'h4c
`define VDPC_ADDR_HIGH 7'h4d
`define VDPC_PHASE_HALF 6'h20
`define VDPC_FRAME_DELAY 4'h8
`define VDPC_FIFO_DEPTH 16
`define VDPC_BYTE_BITS 4'h8
`define VDPC_RST_BYTE 8'h00
`define VDPC_RST_PHASE 6'h00

`endif

//--- design/vdpc_pkg.sv
/*
  Types of the video digitizer pin control block.
  Assumes nothing beyond a SystemVerilog tool.
*/
package vdpc_pkg;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } vdpc_rgb_t;

  typedef struct packed {
    vdpc_rgb_t rgb;
    logic line_sync;
  } vdpc_pix_t;

  typedef enum logic [2:0] {
    SER_IDLE,
    SER_ADDR,
    SER_ADDR_ACK,
    SER_WR,
    SER_WR_ACK,
    SER_RD,
    SER_RD_ACK
  } vdpc_ser_state_t;

endpackage : vdpc_pkg

//--- design/vdpc_top.sv
/*
  Pixel output port, sync outputs, sample phase invert, reset pin filter,
  crystal clock output and 2-wire slave of the video digitizer.
  Assumes one 50 MHz clock; pixel samples arrive from logic on that clock;
  pins are asynchronous and pass two flip-flops first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vdpc_params.svh"

module vdpc_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Fill side
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  // Drain side
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;
  wire ptr_same = wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0];
  assign o_ready = !(ptr_same && (wr_ptr_ff[AW] != rd_ptr_ff[AW]));
  assign o_valid = wr_ptr_ff != rd_ptr_ff;
  assign o_data = mem_ff[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge i_clock)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
      rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
    end
  end
endmodule : vdpc_fifo

module vdpc_top (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Pins from outside
  input wire logic i_reset_pin_n,
  input wire logic i_sample_phase_invert,
  input wire logic i_slave_addr_select,
  input wire logic i_frame_sync_in,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  // Configuration from on-chip logic
  input wire logic i_wide_mode,
  input wire logic i_xtal_div2,
  input wire logic [5:0] i_phase_code,
  output logic [5:0] o_sample_phase,
  // Pixel stream from the converters
  input wire vdpc_pkg::vdpc_pix_t i_pix,
  input wire logic i_pix_valid,
  output logic o_pix_ready,
  // Pixel output port
  output vdpc_pkg::vdpc_rgb_t o_primary,
  output vdpc_pkg::vdpc_rgb_t o_secondary,
  output logic o_pixel_bus_clock,
  output logic o_pixel_bus_clock_n,
  output logic o_aligned_line_sync_out,
  output logic o_aligned_frame_sync_out,
  output logic o_crystal_clock_buffer_out,
  // Control bytes of the 2-wire port
  output logic [7:0] o_ctrl_wdata,
  output logic o_ctrl_wstrobe,
  output logic o_ctrl_rd_req,
  input wire logic [7:0] i_ctrl_rdata
);
  import vdpc_pkg::*;

  // Pin synchronisers, stage one read only by stage two
  logic [5:0] pin_s1_ff;
  logic [5:0] pin_s2_ff;
  logic [1:0] ser_d_ff;
  logic frame_d_ff;
  wire [5:0] pin_raw = {i_reset_pin_n, i_sample_phase_invert,
    i_slave_addr_select, i_frame_sync_in, i_scl, i_sda};

  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      pin_s1_ff <= 6'h23;
      pin_s2_ff <= 6'h23;
      ser_d_ff <= 2'h3;
      frame_d_ff <= 1'b0;
    end
    else
    begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
      ser_d_ff <= pin_s2_ff[1:0];
      frame_d_ff <= pin_s2_ff[2];
    end
  end

  wire rst_pin_n = pin_s2_ff[5];
  wire invert_s = pin_s2_ff[4];
  wire addr_sel_s = pin_s2_ff[3];
  wire frame_s = pin_s2_ff[2];
  wire scl_s = pin_s2_ff[1];
  wire sda_s = pin_s2_ff[0];

  // Reset pin filter: short glitches never reset the core
  logic [5:0] low_cnt_ff;
  logic pin_rst_ff;
  wire low_long = low_cnt_ff == 6'(`VDPC_RST_MIN_CYC - 1);
  wire core_nrst = i_nrst && !pin_rst_ff;

  always_ff @(posedge i_clock)
  begin
    if (!i_nrst || rst_pin_n)
    begin
      low_cnt_ff <= 6'h00;
      pin_rst_ff <= 1'b0;
    end
    else if (!low_long)
    begin
      low_cnt_ff <= low_cnt_ff + 6'h01;
    end
    else
    begin
      pin_rst_ff <= 1'b1;
    end
  end

  // Sampling phase: half a pixel is 32 of 64 steps
  always_ff @(posedge i_clock)
  begin
    if (!core_nrst)
    begin
      o_sample_phase <= `VDPC_RST_PHASE;
    end
    else
    begin
      o_sample_phase <= i_phase_code + (invert_s ? `VDPC_PHASE_HALF
        : 6'h00);
    end
  end

  // Crystal clock copy; core clock / 2 stands for the crystal rate
  logic [1:0] xdiv_ff;
  always_ff @(posedge i_clock)
  begin
    if (!core_nrst)
    begin
      xdiv_ff <= 2'h0;
    end
    else
    begin
      xdiv_ff <= xdiv_ff + 2'h1;
    end
  end
  assign o_crystal_clock_buffer_out = i_xtal_div2 ? xdiv_ff[1]
    : xdiv_ff[0];

  // Pixel path through the FIFO; a full FIFO stalls the converters
  vdpc_pix_t fifo_pix;
  logic fifo_valid;
  logic fifo_take;
  vdpc_fifo #(
    .WIDTH($bits(vdpc_pix_t)),
    .DEPTH(`VDPC_FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_nrst(core_nrst),
    .i_data(i_pix),
    .i_valid(i_pix_valid),
    .o_ready(o_pix_ready),
    .o_data(fifo_pix),
    .o_valid(fifo_valid),
    .i_ready(fifo_take)
  );

  // One pixel beat every second clock; data only changes when ph is 0/2
  logic [1:0] ph_ff;
  vdpc_pix_t hold_ff;
  logic hold_vld_ff;
  logic dclk_ff;
  wire beat = !ph_ff[0];
  assign fifo_take = beat && !(i_wide_mode && ph_ff[1] && hold_vld_ff);
  wire got = fifo_take && fifo_valid;
  wire to_hold = got && i_wide_mode && !hold_vld_ff;
  wire load_pair = got && i_wide_mode && hold_vld_ff && !ph_ff[1];
  wire load_one = got && !i_wide_mode;
  wire hs_pair = hold_ff.line_sync || fifo_pix.line_sync;

  always_ff @(posedge i_clock)
  begin
    if (!core_nrst)
    begin
      ph_ff <= 2'h0;
      dclk_ff <= 1'b0;
      hold_vld_ff <= 1'b0;
      hold_ff <= '0;
    end
    else
    begin
      ph_ff <= ph_ff + 2'h1;
      dclk_ff <= i_wide_mode ? ph_ff[1] : ph_ff[0];
      hold_vld_ff <= to_hold || (hold_vld_ff && !load_pair);
      if (to_hold)
      begin
        hold_ff <= fifo_pix;
      end
    end
  end
  assign o_pixel_bus_clock = dclk_ff;
  assign o_pixel_bus_clock_n = !dclk_ff;

  always_ff @(posedge i_clock)
  begin
    if (!core_nrst)
    begin
      o_primary <= '0;
      o_secondary <= '0;
      o_aligned_line_sync_out <= 1'b0;
    end
    else if (load_pair)
    begin
      o_primary <= hold_ff.rgb;
      o_secondary <= fifo_pix.rgb;
      o_aligned_line_sync_out <= hs_pair;
    end
    else if (load_one)
    begin
      o_primary <= fifo_pix.rgb;
      o_secondary <= '0;
      o_aligned_line_sync_out <= fifo_pix.line_sync;
    end
  end

  // Artificial frame sync, lasting one line
  logic hs_d_ff;
  logic armed_ff;
  logic run_ff;
  logic [3:0] vs_cnt_ff;
  wire hs_trail = hs_d_ff && !o_aligned_line_sync_out;
  wire vs_hit = run_ff && beat && (vs_cnt_ff == `VDPC_FRAME_DELAY - 4'h1);

  always_ff @(posedge i_clock)
  begin
    if (!core_nrst)
    begin
      hs_d_ff <= 1'b0;
      armed_ff <= 1'b0;
      run_ff <= 1'b0;
      vs_cnt_ff <= 4'h0;
      o_aligned_frame_sync_out <= 1'b0;
    end
    else
    begin
      hs_d_ff <= o_aligned_line_sync_out;
      armed_ff <= (frame_s && !frame_d_ff) || (armed_ff && !vs_hit);
      run_ff <= (hs_trail && armed_ff) || (run_ff && !vs_hit);
      if (hs_trail)
      begin
        vs_cnt_ff <= 4'h0;
      end
      else if (run_ff && beat)
      begin
        vs_cnt_ff <= vs_cnt_ff + 4'h1;
      end
      o_aligned_frame_sync_out <= vs_hit
        || (o_aligned_frame_sync_out && !hs_trail);
    end
  end

  // 2-wire slave: SCL is sampled only, SDA is pulled low or released
  vdpc_ser_state_t st_ff;
  vdpc_ser_state_t nxt_st;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic [3:0] bit_ff;
  logic [3:0] nxt_bit;
  logic oe_ff;
  logic nxt_oe;
  logic rw_ff;
  logic nxt_rw;
  wire scl_rise = scl_s && !ser_d_ff[1];
  wire scl_fall = !scl_s && ser_d_ff[1];
  wire start_c = scl_s && ser_d_ff[1] && ser_d_ff[0] && !sda_s;
  wire stop_c = scl_s && ser_d_ff[1] && !ser_d_ff[0] && sda_s;
  wire [6:0] my_addr = addr_sel_s ? `VDPC_ADDR_HIGH : `VDPC_ADDR_LOW;
  wire byte_done = bit_ff == `VDPC_BYTE_BITS;
  wire addr_hit = sh_ff[7:1] == my_addr;
  wire rd_load = scl_fall && ((st_ff == SER_ADDR_ACK && rw_ff)
    || st_ff == SER_RD_ACK);

  always_comb
  begin
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_bit = bit_ff;
    nxt_oe = oe_ff;
    nxt_rw = rw_ff;
    if (start_c)
    begin
      nxt_st = SER_ADDR;
      nxt_bit = 4'h0;
      nxt_oe = 1'b0;
    end
    else if (stop_c)
    begin
      nxt_st = SER_IDLE;
      nxt_oe = 1'b0;
    end
    else if (rd_load)
    begin
      nxt_st = SER_RD;
      nxt_sh = {i_ctrl_rdata[6:0], 1'b0};
      nxt_oe = !i_ctrl_rdata[7];
      nxt_bit = 4'h1;
    end
    else
    begin
      case (st_ff)
        SER_ADDR, SER_WR:
        begin
          if (scl_rise && !byte_done)
          begin
            nxt_sh = {sh_ff[6:0], sda_s};
            nxt_bit = bit_ff + 4'h1;
          end
          else if (scl_fall && byte_done)
          begin
            nxt_oe = st_ff == SER_WR || addr_hit;
            nxt_rw = st_ff == SER_ADDR ? sh_ff[0] : rw_ff;
            nxt_st = st_ff == SER_WR ? SER_WR_ACK
              : addr_hit ? SER_ADDR_ACK : SER_IDLE;
          end
        end
        SER_ADDR_ACK, SER_WR_ACK:
        begin
          if (scl_fall)
          begin
            nxt_oe = 1'b0;
            nxt_st = SER_WR;
            nxt_bit = 4'h0;
          end
        end
        SER_RD:
        begin
          if (scl_fall)
          begin
            nxt_oe = byte_done ? 1'b0 : !sh_ff[7];
            nxt_st = byte_done ? SER_RD_ACK : SER_RD;
            nxt_sh = {sh_ff[6:0], 1'b0};
            nxt_bit = bit_ff + 4'h1;
          end
        end
        SER_RD_ACK:
        begin
          if (scl_rise && sda_s)
          begin
            nxt_st = SER_IDLE;
          end
        end
        default:
        begin
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!core_nrst)
    begin
      st_ff <= SER_IDLE;
      sh_ff <= `VDPC_RST_BYTE;
      bit_ff <= 4'h0;
      oe_ff <= 1'b0;
      rw_ff <= 1'b0;
      o_ctrl_wdata <= `VDPC_RST_BYTE;
      o_ctrl_wstrobe <= 1'b0;
      o_ctrl_rd_req <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      sh_ff <= nxt_sh;
      bit_ff <= nxt_bit;
      oe_ff <= nxt_oe;
      rw_ff <= nxt_rw;
      o_ctrl_wstrobe <= nxt_st == SER_WR_ACK && st_ff == SER_WR;
      o_ctrl_rd_req <= rd_load;
      if (nxt_st == SER_WR_ACK && st_ff == SER_WR)
      begin
        o_ctrl_wdata <= sh_ff;
      end
    end
  end
  assign o_sda = 1'b0;
  assign o_sda_oe = oe_ff;

  // Checks
  sequence trail_s;
    hs_trail && armed_ff && !run_ff;
  endsequence

  // Two runs of eight cover a quiet line of sixteen clocks
  sequence quiet_line_s;
    !hs_trail [*8] ##1 !hs_trail [*8];
  endsequence

  // High now, still low two clocks ago: rose on the 16th or 17th clock
  sequence frame_late_s;
    o_aligned_frame_sync_out && !$past(o_aligned_frame_sync_out, 2);
  endsequence

  phase_half_shift_a: assert property (@(posedge i_clock)
    disable iff (!core_nrst) $stable(invert_s) && $stable(i_phase_code)
    |=> o_sample_phase == $past(i_phase_code)
    + ($past(invert_s) ? 6'h20 : 6'h00))
    else $error("sample phase not shifted by half");

  reset_filter_a: assert property (@(posedge i_clock)
    disable iff (!i_nrst) $rose(pin_rst_ff)
    |-> $past(low_cnt_ff) == 6'(`VDPC_RST_MIN_CYC - 1) && !$past(rst_pin_n))
    else $error("reset taken before the least low time");

  xtal_rate_a: assert property (@(posedge i_clock)
    disable iff (!core_nrst) i_xtal_div2 && $past(i_xtal_div2, 2)
    && $rose(o_crystal_clock_buffer_out) |=> o_crystal_clock_buffer_out)
    else $error("crystal clock copy not halved");

  addr_ack_a: assert property (@(posedge i_clock)
    disable iff (!core_nrst) st_ff == SER_ADDR && scl_fall && byte_done
    && !start_c && !stop_c |=> oe_ff == (sh_ff[7:1] == (addr_sel_s
    ? 7'h4d : 7'h4c)))
    else $error("slave address acknowledge wrong");

  sda_open_drain_a: assert property (@(posedge i_clock)
    disable iff (!core_nrst) o_sda_oe |-> !o_sda)
    else $error("data line driven high");

  dclk_full_rate_a: assert property (@(posedge i_clock)
    disable iff (!core_nrst) !i_wide_mode [*3]
    |-> o_pixel_bus_clock != $past(o_pixel_bus_clock))
    else $error("data clock not at pixel rate");

  dclk_pair_a: assert property (@(posedge i_clock)
    disable iff (!core_nrst) o_pixel_bus_clock_n == !o_pixel_bus_clock)
    else $error("data clock pair not complementary");

  frame_sync_delay_a: assert property (@(posedge i_clock)
    disable iff (!core_nrst) trail_s ##1 quiet_line_s
    |=> frame_late_s)
    else $error("frame sync not 8 pixel clocks after line sync");

  narrow_second_a: assert property (@(posedge i_clock)
    disable iff (!core_nrst) load_one |=> o_secondary == '0
    && o_primary == $past(fifo_pix.rgb))
    else $error("secondary bus active in 24-bit mode");

endmodule : vdpc_top

`default_nettype wire

//--- test/vdpc_sink.sv
/*
  Model of the receiving controller: captures the output port on the rising
  data clock and steers the phase invert pin once per frame.
  Assumes the digitizer core clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module vdpc_sink (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Bench control
  input wire logic i_clear,
  input wire logic i_undersample,
  // Digitizer output port
  input wire logic i_bus_clock,
  input wire vdpc_pkg::vdpc_rgb_t i_primary,
  input wire vdpc_pkg::vdpc_rgb_t i_secondary,
  input wire logic i_frame_sync,
  // Results
  output logic o_phase_invert,
  output logic [7:0] o_period,
  output logic [3:0] o_count
);
  import vdpc_pkg::*;
  logic bclk_ff;
  logic fs_ff;
  logic [7:0] cnt_ff;
  logic [47:0] last_ff;
  logic [47:0] cap [0:15];
  wire logic [47:0] word = {i_primary, i_secondary};
  wire logic rise = i_bus_clock & ~bclk_ff;
  // Only new words are kept, since an empty buffer repeats stale data
  always_ff @(posedge i_clock)
  begin
    bclk_ff <= i_bus_clock;
    fs_ff <= i_frame_sync;
    cnt_ff <= rise ? 8'h00 : cnt_ff + 8'h01;
    if (rise)
      o_period <= cnt_ff + 8'h01;
    if (!i_nrst || i_clear)
    begin
      o_count <= 4'h0;
      last_ff <= word;
    end
    else if (rise && word !== last_ff)
    begin
      cap[o_count] <= word;
      last_ff <= word;
      o_count <= o_count + 4'h1;
    end
    if (!i_nrst || !i_undersample)
      o_phase_invert <= 1'b0;
    else if (i_frame_sync && !fs_ff)
      o_phase_invert <= ~o_phase_invert;
  end
endmodule : vdpc_sink
`default_nettype wire

//--- test/video_digitizer_pin_control_tb.sv
/*
  Self-checking bench of the digitizer pin control block.
  Assumes a 50 MHz core clock; the bench plays the 2-wire master.
*/
`timescale 1ns/1ps
`default_nettype none
module video_digitizer_pin_control_tb;
  import vdpc_pkg::*;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic rst_pin_n = 1'b1, fsync = 1'b0, sel = 1'b0, scl = 1'b1;
  logic sda_m = 1'b1, wide = 1'b0, div2 = 1'b0, clear = 1'b0;
  logic under = 1'b0, pix_valid = 1'b0;
  logic [5:0] code = 6'h00;
  vdpc_pix_t pix = '0;
  logic o_sda, oe, ready, bclk, bclk_n, ls, fs, xclk, wstb, rdreq, inv;
  logic [5:0] phase;
  vdpc_rgb_t prim, sec;
  logic [7:0] wdata, wseen, period, xc, xper, hc, fdel, v;
  logic [7:0] rbyte, rdat = 8'ha5;
  logic [3:0] count;
  logic xq, lq, fq, ack, refused = 0, sda_bad = 0, comp_bad = 0, ls_ok = 0;
  int num_errors = 0, num_checks = 0, wcnt = 0, rcnt = 0, n;
  // Open drain: the line is pulled up unless someone pulls it low
  wire logic sda_line = sda_m & ~oe;
  always #10 i_clock = ~i_clock;
  vdpc_top vdpc_top_i (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_reset_pin_n(rst_pin_n), .i_sample_phase_invert(inv),
    .i_slave_addr_select(sel), .i_frame_sync_in(fsync), .i_scl(scl),
    .i_sda(sda_line), .o_sda(o_sda), .o_sda_oe(oe), .i_wide_mode(wide),
    .i_xtal_div2(div2), .i_phase_code(code), .o_sample_phase(phase),
    .i_pix(pix), .i_pix_valid(pix_valid), .o_pix_ready(ready),
    .o_primary(prim), .o_secondary(sec), .o_pixel_bus_clock(bclk),
    .o_pixel_bus_clock_n(bclk_n), .o_aligned_line_sync_out(ls),
    .o_aligned_frame_sync_out(fs), .o_crystal_clock_buffer_out(xclk),
    .o_ctrl_wdata(wdata), .o_ctrl_wstrobe(wstb), .o_ctrl_rd_req(rdreq),
    .i_ctrl_rdata(rdat));
  vdpc_sink vdpc_sink_i (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_clear(clear), .i_undersample(under), .i_bus_clock(bclk),
    .i_primary(prim), .i_secondary(sec), .i_frame_sync(fs),
    .o_phase_invert(inv), .o_period(period), .o_count(count));
  always @(posedge i_clock)
  begin
    xq <= xclk;
    xc <= (xclk & ~xq) ? 8'h01 : xc + 8'h01;
    if (xclk & ~xq)
      xper <= xc;
    lq <= ls;
    fq <= fs;
    hc <= (lq & ~ls) ? 8'h01 : hc + 8'h01;
    if (fs & ~fq)
      fdel <= hc;
    if (pix_valid && ready === 1'b0)
      refused <= 1'b1;
    if (ls === 1'b1 && prim === 24'h123456)
      ls_ok <= 1'b1;
    if (wstb === 1'b1)
      wseen <= wdata;
    if (wstb === 1'b1)
      wcnt <= wcnt + 1;
    if (rdreq === 1'b1)
      rcnt <= rcnt + 1;
    if (o_sda !== 1'b0)
      sda_bad <= 1'b1;
    if (i_nrst && bclk_n !== ~bclk)
      comp_bad <= 1'b1;
  end
  task wt(input int c);
    repeat (c) @(posedge i_clock);
  endtask : wt
  task check(input string nm, input logic [47:0] s, input logic [47:0] e);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // Leaves valid high so back-to-back pushes need no idle cycle
  task push(input logic [23:0] c, input logic s);
    pix <= {c, s};
    pix_valid <= 1'b1;
    n = 0;
    do
    begin
      @(negedge i_clock);
      n++;
    end while (ready !== 1'b1 && n < 100);
    if (n >= 100)
    begin
      num_errors++;
      wrap_up();
    end
    @(posedge i_clock);
  endtask : push
  task tw_bit(input logic b, output logic r);
    sda_m <= b;
    wt(5);
    scl <= 1'b1;
    wt(5);
    @(negedge i_clock);
    r = sda_line;
    wt(5);
    scl <= 1'b0;
    wt(5);
  endtask : tw_bit
  // The line as seen at each high clock lands in rbyte, MSB first
  task tw_byte(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--)
      tw_bit(b[i], rbyte[i]);
    tw_bit(1'b1, a);
  endtask : tw_byte
  initial
  begin
    repeat (90000) @(posedge i_clock);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    wt(8);
    i_nrst <= 1'b1;
    wt(30);
    @(negedge i_clock);
    check("sda oe", oe, 0);
    check("phase", phase, 0);
    check("period 24", period, 2);
    check("xtal full", xper, 2);
    div2 <= 1'b1;
    wt(20);
    check("xtal half", xper, 4);
    clear <= 1'b1;
    wt(1);
    clear <= 1'b0;
    for (int k = 0; k < 40; k++)
      push(24'(24'h010101 * (k + 1)), 1'b0);
    pix_valid <= 1'b0;
    wt(100);
    check("refused", refused, 1);
    check("count", count, 8);
    for (int k = 0; k < 16; k++)
      check("cap 24", vdpc_sink_i.cap[k],
        {24'(24'h010101 * ((k < 8) ? k + 33 : k + 17)), 24'h0});
    wide <= 1'b1;
    clear <= 1'b1;
    wt(1);
    clear <= 1'b0;
    wt(8);
    push(24'haaaaaa, 1'b0);
    push(24'hbbbbbb, 1'b0);
    push(24'hcccccc, 1'b0);
    push(24'hdddddd, 1'b0);
    pix_valid <= 1'b0;
    wt(40);
    check("pair 0", vdpc_sink_i.cap[0], 48'haaaaaabbbbbb);
    check("pair 1", vdpc_sink_i.cap[1], 48'hccccccdddddd);
    check("period 48", period, 4);
    wide <= 1'b0;
    code <= 6'h28;
    under <= 1'b1;
    fsync <= 1'b1;
    wt(20);
    check("phase plain", phase, 6'h28);
    push(24'h123456, 1'b1);
    push(24'h111111, 1'b0);
    push(24'h333333, 1'b0);
    pix_valid <= 1'b0;
    n = 0;
    while (fs !== 1'b1 && n < 200)
    begin
      wt(1);
      n++;
    end
    if (n >= 200)
    begin
      num_errors++;
      wrap_up();
    end
    fsync <= 1'b0;
    wt(8);
    @(negedge i_clock);
    check("frame sync", fs, 1);
    check("frame delay", fdel >= 16 && fdel <= 17, 1);
    check("line sync", ls_ok, 1);
    check("phase inverted", phase, 6'h08);
    rst_pin_n <= 1'b0;
    wt(30);
    rst_pin_n <= 1'b1;
    wt(10);
    check("short reset", prim, 24'h333333);
    rst_pin_n <= 1'b0;
    wt(80);
    check("long reset data", prim, 0);
    check("long reset clock", bclk, 0);
    rst_pin_n <= 1'b1;
    wt(20);
    for (int s = 0; s < 2; s++)
      for (int a = 0; a < 2; a++)
      begin
        sel <= s[0];
        v = a[0] ? 8'h9a : 8'h98;
        wt(10);
        sda_m <= 1'b0;
        wt(10);
        scl <= 1'b0;
        wt(5);
        tw_byte(v, ack);
        check("addr ack", ack, (a == s) ? 0 : 1);
        if (a == s)
        begin
          tw_byte(8'h5a + s[7:0], ack);
          check("data ack", ack, 0);
          check("wdata", wseen, 8'h5a + s[7:0]);
        end
        sda_m <= 1'b0;
        wt(5);
        scl <= 1'b1;
        wt(10);
        sda_m <= 1'b1;
      end
    check("writes", wcnt, 2);
    // One read: address byte with the read bit, then a byte out and NACK
    sel <= 1'b0;
    wt(10);
    sda_m <= 1'b0;
    wt(10);
    scl <= 1'b0;
    wt(5);
    tw_byte(8'h99, ack);
    check("read addr ack", ack, 0);
    tw_byte(8'hff, ack);
    check("read byte", rbyte, 8'ha5);
    check("read requests", rcnt, 1);
    sda_m <= 1'b0;
    wt(5);
    scl <= 1'b1;
    wt(10);
    sda_m <= 1'b1;
    wt(10);
    check("sda high", sda_bad, 0);
    check("clock pair", comp_bad, 0);
    wrap_up();
  end
endmodule : video_digitizer_pin_control_tb
`default_nettype wire
